// ---- logic/dsw_pkg.sv ----
/*
  constants, register map and carrier types of the drive status word encoder.
  assumes one pclk domain and an apb master with 8-bit byte addressing.
*/
package dsw_pkg;
  // word widths
  localparam int unsigned WORD_W = 16;
  localparam int unsigned APB_AW = 8;
  // status word bit positions
  localparam int unsigned BIT_FREQ_OK = 10;
  localparam int unsigned BIT_IN_OP = 11;
  localparam int unsigned BIT_TEMP_STOP = 12;
  localparam int unsigned BIT_VOLT = 13;
  localparam int unsigned BIT_TORQUE = 14;
  localparam int unsigned BIT_TIMER = 15;
  // relative scaling: 16'h4000 is one hundred percent
  localparam logic [15:0] FULL_SCALE = 16'h4000;
  localparam logic [15:0] POS_MAX = 16'h7fff;
  // register byte offsets
  localparam logic [7:0] OFS_SPEED_REF = 8'h00;
  localparam logic [7:0] OFS_LOW_LIM = 8'h04;
  localparam logic [7:0] OFS_HIGH_LIM = 8'h08;
  localparam logic [7:0] OFS_CUR_LIM = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_ACT_FREQ = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
  // register reset values
  localparam logic [15:0] RST_SPEED_REF = 16'h0000;
  localparam logic [15:0] RST_LOW_LIM = 16'h0000;
  localparam logic [15:0] RST_HIGH_LIM = 16'h4000;
  localparam logic [15:0] RST_CUR_LIM = 16'h4000;
  localparam logic [4:0] RST_IRQ_MASK = 5'h00;
  // interrupt status bit positions
  localparam int unsigned IRQ_TEMP = 0;
  localparam int unsigned IRQ_VOLT = 1;
  localparam int unsigned IRQ_TORQUE = 2;
  localparam int unsigned IRQ_TIMER = 3;
  localparam int unsigned IRQ_LINK = 4;
  localparam int unsigned IRQ_W = 5;
  // drive-side inputs, all asynchronous to pclk
  typedef struct packed {
    logic start_cmd;
    logic over_temp_halt;
    logic dc_under;
    logic dc_over;
    logic link_lost;
    logic comm_fault;
    logic [15:0] out_freq;
    logic [15:0] motor_current;
    logic [15:0] motor_timer;
    logic [15:0] drive_timer;
  } dsw_drive_in_t;
endpackage

// ---- logic/dsw_sync.sv ----
/*
  two-flop synchroniser, one pair of flops per bit.
  assumes each bit is a slow level; multi-bit words are sampled while steady.
*/
`timescale 1ns/1ns
module dsw_sync #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  // one pair of stages per bit
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_q; // first stage, read only by the second
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q <= 1'b0;
        q[i] <= 1'b0;
      end else begin
        meta_q <= d[i];
        q[i] <= meta_q;
      end
    end
  end
endmodule

// ---- logic/dsw_top.sv ----
/*
  drive status word encoder: builds status bits 10..15, passes the actual
  frequency word, holds the bus speed reference, apb register file, irq.
  assumes drive inputs are slow levels from another domain and an apb3 master.
*/
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ns
// Summary of operation
// - bit 11 set on start or nonzero frequency
// - bit 12 set during non-tripping overtemperature stop
// - bit 13 set when dc link out of range
// - bit 14 set when current exceeds limit
// - bit 15 set when either thermal timer exceeds full
// - whole word zero on link loss or fault
// - speed reference 16-bit, 16'h4000 equals 100 percent
// - negative reference values in two's complement
// - actual frequency word uses reference scaling
// - bit 10 set while frequency inside limits
module dsw_top (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive-side inputs
  input wire dsw_pkg::dsw_drive_in_t drv_in,
  // fieldbus-side words
  output logic [15:0] drive_status_word,
  output logic [15:0] actual_output_frequency_word,
  output logic [15:0] speed_reference_word,
  // interrupt
  output logic irq
);

  // synchronised drive inputs
  dsw_pkg::dsw_drive_in_t s;
  // apb handshake state
  logic pready_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  // software registers
  logic [15:0] speed_ref_q;
  logic [15:0] low_lim_q;
  logic [15:0] high_lim_q;
  logic [15:0] cur_lim_q;
  logic [dsw_pkg::IRQ_W-1:0] irq_stat_q;
  logic [dsw_pkg::IRQ_W-1:0] irq_mask_q;
  logic irq_q;
  // assembled words
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] act_freq_q;
  // helpers
  logic link_ok;
  logic [16:0] freq_mag;
  logic freq_nonzero;
  logic freq_in_lim;
  logic cur_over;
  logic timer_over;
  logic acc;
  logic wr_en;
  logic rd_en;
  logic addr_hit;
  logic [dsw_pkg::IRQ_W-1:0] evt;
  logic [dsw_pkg::IRQ_W-1:0] evt_lvl;
  logic [dsw_pkg::IRQ_W-1:0] evt_lvl_q;
  logic [dsw_pkg::IRQ_W-1:0] w1c;

  // two-flop crossing for every drive input bit
  dsw_sync #(
    .WIDTH($bits(dsw_pkg::dsw_drive_in_t))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(drv_in),
    .q(s)
  );

  // link health: loss or internal fault blanks the word
  assign link_ok = !s.link_lost && !s.comm_fault;

  // magnitude of signed frequency, 17 bits so -32768 fits
  always_comb begin
    if (s.out_freq[15]) begin
      freq_mag = 17'h00000 - {1'b1, s.out_freq};
    end else begin
      freq_mag = {1'b0, s.out_freq};
    end
  end

  // running when any frequency is produced
  assign freq_nonzero = (s.out_freq != 16'h0000);
  // strictly between limits; reaching either drops the bit
  assign freq_in_lim = (freq_mag > {1'b0, low_lim_q}) &&
                       (freq_mag < {1'b0, high_lim_q});
  // current above software limit
  assign cur_over = (s.motor_current > cur_lim_q);
  // either thermal timer past full scale
  assign timer_over = (s.motor_timer > dsw_pkg::FULL_SCALE) ||
                      (s.drive_timer > dsw_pkg::FULL_SCALE);

  // status word assembly; bits 0..9 are outside this block
  always_comb begin
    status_d = 16'h0000;
    status_d[dsw_pkg::BIT_FREQ_OK] = freq_in_lim;
    status_d[dsw_pkg::BIT_IN_OP] = s.start_cmd || freq_nonzero;
    status_d[dsw_pkg::BIT_TEMP_STOP] = s.over_temp_halt;
    status_d[dsw_pkg::BIT_VOLT] = s.dc_under || s.dc_over;
    status_d[dsw_pkg::BIT_TORQUE] = cur_over;
    status_d[dsw_pkg::BIT_TIMER] = timer_over;
    // blanking overrides every bit
    if (!link_ok) begin
      status_d = 16'h0000;
    end
  end

  // status word register, once per clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= 16'h0000;
    end else begin
      status_q <= status_d;
    end
  end

  // actual frequency passes in the reference scaling unchanged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_freq_q <= 16'h0000;
    end else begin
      act_freq_q <= s.out_freq;
    end
  end

  // apb decode: one wait state, then pready for one cycle
  assign acc = psel && penable;
  assign wr_en = acc && pready_q && pwrite;
  assign rd_en = acc && !pready_q && !pwrite;
  always_comb begin
    unique case (paddr)
      dsw_pkg::OFS_SPEED_REF, dsw_pkg::OFS_LOW_LIM,
      dsw_pkg::OFS_HIGH_LIM, dsw_pkg::OFS_CUR_LIM,
      dsw_pkg::OFS_STATUS, dsw_pkg::OFS_ACT_FREQ,
      dsw_pkg::OFS_IRQ_STAT, dsw_pkg::OFS_IRQ_MASK: begin
        addr_hit = 1'b1;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  // pready and error, answered one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc && !pready_q;
      pslverr_q <= acc && !pready_q && !addr_hit;
    end
  end

  // read data, captured together with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (rd_en) begin
      unique case (paddr)
        dsw_pkg::OFS_SPEED_REF: begin
          prdata_q <= {16'h0000, speed_ref_q};
        end
        dsw_pkg::OFS_LOW_LIM: begin
          prdata_q <= {16'h0000, low_lim_q};
        end
        dsw_pkg::OFS_HIGH_LIM: begin
          prdata_q <= {16'h0000, high_lim_q};
        end
        dsw_pkg::OFS_CUR_LIM: begin
          prdata_q <= {16'h0000, cur_lim_q};
        end
        dsw_pkg::OFS_STATUS: begin
          prdata_q <= {16'h0000, status_q};
        end
        dsw_pkg::OFS_ACT_FREQ: begin
          prdata_q <= {16'h0000, act_freq_q};
        end
        dsw_pkg::OFS_IRQ_STAT: begin
          prdata_q <= {27'h0000000, irq_stat_q};
        end
        dsw_pkg::OFS_IRQ_MASK: begin
          prdata_q <= {27'h0000000, irq_mask_q};
        end
        default: begin
          prdata_q <= 32'h00000000;
        end
      endcase
    end else if (!acc) begin
      prdata_q <= 32'h00000000;
    end
  end

  // speed reference: full 16-bit signed word, 16'h4000 is 100 percent
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_ref_q <= dsw_pkg::RST_SPEED_REF;
    end else if (wr_en && paddr == dsw_pkg::OFS_SPEED_REF) begin
      speed_ref_q <= pwdata[15:0];
    end
  end

  // speed and current limits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_lim_q <= dsw_pkg::RST_LOW_LIM;
      high_lim_q <= dsw_pkg::RST_HIGH_LIM;
      cur_lim_q <= dsw_pkg::RST_CUR_LIM;
    end else if (wr_en) begin
      if (paddr == dsw_pkg::OFS_LOW_LIM) begin
        low_lim_q <= pwdata[15:0];
      end
      if (paddr == dsw_pkg::OFS_HIGH_LIM) begin
        high_lim_q <= pwdata[15:0];
      end
      if (paddr == dsw_pkg::OFS_CUR_LIM) begin
        cur_lim_q <= pwdata[15:0];
      end
    end
  end

  // event levels: fault bits and link loss
  assign evt_lvl = {!link_ok, status_d[dsw_pkg::BIT_TIMER],
                    status_d[dsw_pkg::BIT_TORQUE], status_d[dsw_pkg::BIT_VOLT],
                    status_d[dsw_pkg::BIT_TEMP_STOP]};
  // rising edges become events
  assign evt = evt_lvl & ~evt_lvl_q;
  // write-one-to-clear pattern
  assign w1c = (wr_en && paddr == dsw_pkg::OFS_IRQ_STAT) ?
               pwdata[dsw_pkg::IRQ_W-1:0] : '0;

  // previous event levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_lvl_q <= '0;
    end else begin
      evt_lvl_q <= evt_lvl;
    end
  end

  // sticky interrupt status; a new event beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~w1c) | evt;
    end
  end

  // interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= dsw_pkg::RST_IRQ_MASK;
    end else if (wr_en && paddr == dsw_pkg::OFS_IRQ_MASK) begin
      irq_mask_q <= pwdata[dsw_pkg::IRQ_W-1:0];
    end
  end

  // level interrupt from masked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign drive_status_word = status_q;
  assign actual_output_frequency_word = act_freq_q;
  assign speed_reference_word = speed_ref_q;
  assign irq = irq_q;

  // running flag follows start or frequency one cycle later
  in_op_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (link_ok && (s.start_cmd || freq_nonzero)) |=> drive_status_word[11]
  ) else $error("in operation bit not set");

  // overtemperature stop flag tracks its input
  temp_stop_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    link_ok |=> (drive_status_word[12] == $past(s.over_temp_halt))
  ) else $error("temperature stop bit wrong");

  // dc link flag clear without under or over voltage
  volt_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (link_ok && !s.dc_under && !s.dc_over) |=> !drive_status_word[13]
  ) else $error("voltage bit set without warning");

  // torque flag against current limit
  torque_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (link_ok && s.motor_current > cur_lim_q) |=> drive_status_word[14]
  ) else $error("torque bit not set over limit");

  // timer flag cleared while both timers at or below full
  timer_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (s.motor_timer <= 16'h4000 && s.drive_timer <= 16'h4000)
      |=> !drive_status_word[15]
  ) else $error("timer bit set at or below full scale");

  // lost link blanks the whole word
  link_blank_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !link_ok |=> (drive_status_word == 16'h0000)
  ) else $error("status word not blanked on link loss");

  // reference changes only by a completed write
  ref_write_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$stable(speed_reference_word) |->
      $past(wr_en) && ($past(paddr) == 8'h00)
  ) else $error("speed reference changed without write");

  // actual frequency word copies the signed input
  act_freq_copy_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1 |=> (actual_output_frequency_word == $past(s.out_freq))
  ) else $error("actual frequency word not copied");

  // frequency limit flag drops when a limit is reached
  freq_lim_flag_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (freq_mag >= {1'b0, high_lim_q} || freq_mag <= {1'b0, low_lim_q})
      |=> !drive_status_word[10]
  ) else $error("frequency limit bit set at limit");

  // word is zero at the first edge after reset release
  reset_zero_a: assert property (
    @(posedge pclk)
    $rose(presetn) |-> (drive_status_word == 16'h0000)
  ) else $error("status word not zero after reset");

endmodule

// ---- test/dsw_fb_peer.sv ----
/*
  fieldbus option model: takes the status word each clock and raises a link
  fault level on command. assumes the pclk domain of the encoder.
*/
`timescale 1ns/1ns
module dsw_fb_peer (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench command: break the link
  input wire logic drop,
  // words from the encoder
  input wire logic [15:0] status_word,
  input wire logic [15:0] freq_word,
  // link state and captured words
  output logic link_lost,
  output logic [15:0] seen_status,
  output logic [15:0] seen_freq
);
  // link level follows the command one clock later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_lost <= 1'b0;
    end else begin
      link_lost <= drop;
    end
  end
  // capture words as a bus master would, signed relative scaling kept raw
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_status <= 16'h0000;
      seen_freq <= 16'h0000;
    end else begin
      seen_status <= status_word;
      seen_freq <= freq_word;
    end
  end
endmodule

// ---- test/tb.sv ----
/*
  self-checking bench of the status word encoder: apb tasks, drive input
  steps and word checks. assumes the encoder answers apb with pready.
*/
`timescale 1ns/1ns
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dsw_pkg::dsw_drive_in_t din = '0; // bench-driven drive levels
  dsw_pkg::dsw_drive_in_t drv; // with the peer's link level merged
  logic drop = 1'b0;
  logic link_lost;
  logic [15:0] sw;
  logic [15:0] af;
  logic [15:0] sr;
  logic [15:0] seen_s;
  logic [15:0] seen_f;
  logic irq;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int compares = 0;
  // 20 MHz clock
  always #25 pclk = ~pclk;
  always_comb begin
    drv = din;
    drv.link_lost = link_lost;
  end
  dsw_top u_dsw_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drv_in(drv),
    .drive_status_word(sw), .actual_output_frequency_word(af), .speed_reference_word(sr), .irq(irq));
  dsw_fb_peer u_dsw_fb_peer (.pclk(pclk), .presetn(presetn), .drop(drop), .status_word(sw),
    .freq_word(af), .link_lost(link_lost), .seen_status(seen_s), .seen_freq(seen_f));
  // verdict and end of run
  task automatic final_report();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave needs; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // step the drive levels; wait out synchroniser, word register and irq flop
  task automatic step(input dsw_pkg::dsw_drive_in_t s);
    @(posedge pclk);
    din <= s;
    repeat (5) @(posedge pclk);
  endtask
  dsw_pkg::dsw_drive_in_t s;
  logic [15:0] ew;
  initial begin
    #100000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    chk("status at reset", 32'h0, {16'h0, sw});
    // reset values and unmapped place
    rchk("speed ref rst", dsw_pkg::OFS_SPEED_REF, {16'h0, dsw_pkg::RST_SPEED_REF});
    rchk("high lim rst", dsw_pkg::OFS_HIGH_LIM, {16'h0, dsw_pkg::RST_HIGH_LIM});
    rchk("cur lim rst", dsw_pkg::OFS_CUR_LIM, {16'h0, dsw_pkg::RST_CUR_LIM});
    rchk("mask rst", dsw_pkg::OFS_IRQ_MASK, 32'h0);
    chk("mapped err", 32'h0, {31'h0, err});
    rchk("unmapped", 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("test regs done");
    // signed relative reference: +100 and -100 percent
    apb(1'b1, dsw_pkg::OFS_SPEED_REF, 32'h0000_4000);
    // the write lands at the pready edge; look one edge later
    @(posedge pclk);
    chk("ref +100", 32'h4000, {16'h0, sr});
    apb(1'b1, dsw_pkg::OFS_SPEED_REF, 32'h0000_c000);
    rchk("ref -100", dsw_pkg::OFS_SPEED_REF, 32'h0000_c000);
    $display("test reference done");
    // frequency word, bit 10 and bit 11
    s = '0;
    s.start_cmd = 1'b1;
    step(s);
    chk("start bit11", 32'h0800, {16'h0, sw});
    s = '0;
    s.out_freq = 16'h2000;
    step(s);
    chk("in limits", 32'h0c00, {16'h0, sw});
    chk("freq word", 32'h2000, {16'h0, af});
    s.out_freq = 16'hc000;
    step(s);
    chk("at -100", 32'h0800, {16'h0, sw});
    rchk("freq reg", dsw_pkg::OFS_ACT_FREQ, 32'h0000_c000);
    chk("peer freq", 32'hc000, {16'h0, seen_f});
    apb(1'b1, dsw_pkg::OFS_LOW_LIM, 32'h0000_2000);
    s.out_freq = 16'h2000;
    step(s);
    chk("at low lim", 32'h0800, {16'h0, sw});
    apb(1'b1, dsw_pkg::OFS_LOW_LIM, 32'h0);
    s = '0;
    step(s);
    chk("idle word", 32'h0, {16'h0, sw});
    $display("test frequency done");
    // event bits 12..15, each raised; 12 and 14 dropped, 13 and 15 held by the other source
    for (int i = 0; i < 4; i++) begin
      s = '0;
      case (i)
        0: s.over_temp_halt = 1'b1;
        1: s.dc_over = 1'b1;
        2: s.motor_current = 16'h4001;
        default: s.drive_timer = 16'h4001;
      endcase
      ew = 16'h1000 << i;
      step(s);
      chk("event bit", {16'h0, ew}, {16'h0, sw});
      s.motor_current = (i == 2) ? 16'h4000 : 16'h0;
      s.drive_timer = (i == 3) ? 16'h4000 : 16'h0;
      s.over_temp_halt = 1'b0;
      s.dc_over = 1'b0;
      s.dc_under = (i == 1);
      s.motor_timer = (i == 3) ? 16'h4001 : 16'h0;
      step(s);
      chk("event edge", {16'h0, (i == 1 || i == 3) ? ew : 16'h0}, {16'h0, sw});
    end
    $display("test events done");
    // link loss and internal fault blank the word
    s = '0;
    s.out_freq = 16'h2000;
    s.dc_over = 1'b1;
    step(s);
    @(posedge pclk);
    drop <= 1'b1;
    repeat (5) @(posedge pclk);
    chk("link lost", 32'h0, {16'h0, sw});
    chk("freq kept", 32'h2000, {16'h0, af});
    @(posedge pclk);
    drop <= 1'b0;
    s.comm_fault = 1'b1;
    step(s);
    chk("comm fault", 32'h0, {16'h0, sw});
    chk("peer blank", 32'h0, {16'h0, seen_s});
    s = '0;
    step(s);
    $display("test link done");
    // interrupt: clear, mask, raise, clear
    apb(1'b1, dsw_pkg::OFS_IRQ_STAT, 32'h1f);
    rchk("stat clear", dsw_pkg::OFS_IRQ_STAT, 32'h0);
    apb(1'b1, dsw_pkg::OFS_IRQ_MASK, 32'h2);
    s.over_temp_halt = 1'b1;
    step(s);
    chk("masked irq", 32'h0, {31'h0, irq});
    s.dc_under = 1'b1;
    step(s);
    chk("irq up", 32'h1, {31'h0, irq});
    rchk("stat bits", dsw_pkg::OFS_IRQ_STAT, 32'h3);
    apb(1'b1, dsw_pkg::OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge pclk);
    chk("irq down", 32'h0, {31'h0, irq});
    rchk("stat left", dsw_pkg::OFS_IRQ_STAT, 32'h1);
    $display("test irq done");
    final_report();
  end
endmodule
